// ===== hdl/gp_pin_map.svh
// register indices, field positions, reset values and codes of the pin settings block
`ifndef GP_PIN_MAP_SVH
`define GP_PIN_MAP_SVH

`define GP_PIN_COUNT 4
`define GP_IDX_WORK0 4'h0
`define GP_IDX_NV0 4'h4
`define GP_IDX_CTRL 4'h8
`define GP_IDX_STAT 4'h9
`define GP_IDX_LAST 4'h9

`define GP_BIT_LEVEL 4
`define GP_BIT_DIR 3
`define GP_SET_MASK 8'h1F

`define GP_CTRL_RELOAD 0
`define GP_CTRL_RISE 5
`define GP_CTRL_FALL 6
`define GP_CTRL_MASK 8'h60
`define GP_CTRL_RESET 8'h60
`define GP_STAT_FLAG 0
`define GP_SETTLE_DONE 2'h3

`define GP_FACTORY0 8'h12
`define GP_FACTORY1 8'h13
`define GP_FACTORY2 8'h11
`define GP_FACTORY3 8'h11
`define GP_WORK_RESET 8'h08

`define GP_FN_GPIO 3'h0
`define GP_FN_DEDICATED 3'h1
`define GP_FN_ALT0 3'h2
`define GP_FN_ALT1 3'h3
`define GP_FN_ALT2 3'h4

`define GP_RESP_OKAY 2'h0
`define GP_RESP_SLVERR 2'h2

`endif

// ===== hdl/gp_pin_pkg.sv
// types shared by the pin settings block
package gp_pin_pkg;

  typedef struct packed {
    logic [2:0] reserved;
    logic default_out_level;
    logic pin_direction;
    logic [2:0] pin_function_select;
  } pin_setting_s;

  typedef struct packed {
    logic suspend_indicator;
    logic uart_receive_activity_lamp;
    logic uart_transmit_activity_lamp;
    logic bus_configured_indicator;
    logic two_wire_traffic_lamp;
    logic clock_out;
  } alt_sources_s;

  typedef enum logic {
    COPY_LOAD,
    COPY_RUN
  } copy_state_e;

endpackage : gp_pin_pkg

// ===== hdl/pin_sync.sv
// two-stage synchroniser for the general purpose pin inputs
`timescale 1ns/10ps
module pin_sync (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [3:0] async_in,
  output logic [3:0] sync_out
);
  logic [3:0] stage1_reg;
  logic [3:0] stage2_reg;

  // stage one feeds stage two only
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      stage1_reg <= 4'h0;
      stage2_reg <= 4'h0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;
endmodule : pin_sync

// ===== hdl/pin_cell.sv
// drive and level selection for one general purpose pin
`timescale 1ns/10ps
`include "gp_pin_map.svh"
module pin_cell (
  input wire gp_pin_pkg::pin_setting_s setting_in,
  input wire logic alt_valid_in,
  input wire logic alt_drive_in,
  input wire logic alt_level_in,
  output logic drive_out,
  output logic level_out
);
  logic is_gpio;

  assign is_gpio = setting_in.pin_function_select == `GP_FN_GPIO;
  // direction and default level only count in plain i/o
  assign drive_out = is_gpio ? ~setting_in.pin_direction
                   : (alt_valid_in & alt_drive_in);
  assign level_out = is_gpio ? (~setting_in.pin_direction & setting_in.default_out_level)
                   : (alt_valid_in & alt_drive_in & alt_level_in);
endmodule : pin_cell

// ===== hdl/gp_pin_function_settings.sv
// pin function settings with working and non-volatile copies behind an axi4-lite slave
`timescale 1ns/10ps
`include "gp_pin_map.svh"
module gp_pin_function_settings (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire gp_pin_pkg::alt_sources_s alt_sources_in,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe_out,
  output logic [2:0] analog_in_connect_out,
  output logic [1:0] analog_out_connect_out,
  output logic detector_flag_out
);
  localparam logic [7:0] FACTORY [4] = '{`GP_FACTORY0, `GP_FACTORY1, `GP_FACTORY2,
                                         `GP_FACTORY3};

  function automatic logic [3:0] reg_index(input logic [7:0] addr);
    return addr[5:2];
  endfunction : reg_index

  function automatic logic reg_mapped(input logic [7:0] addr);
    return (addr[7:6] == 2'h0) && (addr[5:2] <= `GP_IDX_LAST);
  endfunction : reg_mapped

  // highest legal function code differs per pin
  function automatic logic alt_ok(input logic [1:0] pin, input logic [2:0] fsel);
    logic [2:0] top;
    top = (pin == 2'h0) ? `GP_FN_ALT0 : ((pin == 2'h1) ? `GP_FN_ALT2 : `GP_FN_ALT1);
    return (fsel != `GP_FN_GPIO) && (fsel <= top);
  endfunction : alt_ok

  // bus slave state
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic aw_have_reg, aw_have_next;
  logic w_have_reg, w_have_next;
  logic [7:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // settings state
  logic [7:0] nv_reg [4];
  logic [7:0] work_reg [4];
  logic [7:0] ctrl_reg;
  gp_pin_pkg::copy_state_e copy_state_reg, copy_state_next;
  logic detector_flag_reg, detector_flag_next;
  logic pin1_prev_reg;
  logic [1:0] settle_reg;
  logic [3:0] pin_out_reg, pin_oe_reg;
  logic [2:0] ain_reg;
  logic [1:0] aout_reg;

  logic aw_taken, w_taken, ar_taken, do_write, wr_fire, wr_ok;
  logic [3:0] wr_idx, rd_idx;
  logic [3:0] wr_work, wr_nv;
  logic wr_ctrl, wr_stat, reload_req, rd_ok;
  logic [7:0] rd_byte, status_byte;
  logic [3:0] pin_level;
  logic [2:0] fsel [4];
  logic [3:0] alt_valid, alt_drive, alt_level;
  logic [3:0] drive_next, level_next;
  logic rise, fall, trig, flag_clr, edge_armed;

  // write channel: address and data taken in either order, answer after both
  assign aw_taken = s_axi_awvalid_in & awready_reg;
  assign w_taken = s_axi_wvalid_in & wready_reg;
  assign do_write = aw_have_reg & w_have_reg & ~bvalid_reg;
  assign aw_have_next = aw_taken | (aw_have_reg & ~do_write);
  assign w_have_next = w_taken | (w_have_reg & ~do_write);
  assign bvalid_next = do_write | (bvalid_reg & ~s_axi_bready_in);
  assign awready_next = ~aw_have_next & ~bvalid_next;
  assign wready_next = ~w_have_next & ~bvalid_next;
  assign wr_idx = reg_index(awaddr_reg);
  assign wr_ok = reg_mapped(awaddr_reg);
  // only lane 0 carries a register; other lanes are ignored
  assign wr_fire = do_write & wr_ok & wstrb0_reg;
  assign wr_ctrl = wr_fire & (wr_idx == `GP_IDX_CTRL);
  assign wr_stat = wr_fire & (wr_idx == `GP_IDX_STAT);
  assign reload_req = wr_ctrl & wdata_reg[`GP_CTRL_RELOAD];

  // read channel: one-cycle answer
  assign ar_taken = s_axi_arvalid_in & arready_reg;
  assign rvalid_next = ar_taken | (rvalid_reg & ~s_axi_rready_in);
  assign arready_next = ~rvalid_next;
  assign rd_idx = reg_index(s_axi_araddr_in);
  assign rd_ok = reg_mapped(s_axi_araddr_in);
  assign status_byte = {pin_level, 3'h0, detector_flag_reg};
  assign rd_byte = (rd_idx < `GP_IDX_NV0) ? work_reg[rd_idx[1:0]]
                 : (rd_idx < `GP_IDX_CTRL) ? nv_reg[rd_idx[1:0]]
                 : (rd_idx == `GP_IDX_CTRL) ? ctrl_reg
                 : status_byte;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
    end else begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      bvalid_reg <= bvalid_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      awaddr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      bresp_reg <= `GP_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `GP_RESP_OKAY;
    end else begin
      if (aw_taken) awaddr_reg <= s_axi_awaddr_in;
      if (w_taken) wdata_reg <= s_axi_wdata_in[7:0];
      if (w_taken) wstrb0_reg <= s_axi_wstrb_in[0];
      if (do_write) bresp_reg <= wr_ok ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
      if (ar_taken) rdata_reg <= rd_ok ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      if (ar_taken) rresp_reg <= rd_ok ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
    end
  end

  // copy sequencer: load from non-volatile store after reset and on reload
  always_comb begin
    copy_state_next = copy_state_reg;
    case (copy_state_reg)
      gp_pin_pkg::COPY_LOAD: copy_state_next = gp_pin_pkg::COPY_RUN;
      gp_pin_pkg::COPY_RUN: begin
        if (reload_req) copy_state_next = gp_pin_pkg::COPY_LOAD;
      end
      default: copy_state_next = gp_pin_pkg::COPY_LOAD;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) copy_state_reg <= gp_pin_pkg::COPY_LOAD;
    else copy_state_reg <= copy_state_next;
  end

  // reserved top bits are dropped and read back as zero
  genvar n;
  generate
    for (n = 0; n < `GP_PIN_COUNT; n = n + 1) begin : g_pin
      assign wr_work[n] = wr_fire & (wr_idx == (`GP_IDX_WORK0 + 4'(n)));
      assign wr_nv[n] = wr_fire & (wr_idx == (`GP_IDX_NV0 + 4'(n)));
      assign fsel[n] = work_reg[n][2:0];

      // store image; factory image returns on power-on reset only
      always_ff @(posedge clock_in) begin
        if (reset_in) nv_reg[n] <= FACTORY[n];
        else if (wr_nv[n]) nv_reg[n] <= wdata_reg & `GP_SET_MASK;
      end

      // safe input state until the store image lands
      always_ff @(posedge clock_in) begin
        if (reset_in) work_reg[n] <= `GP_WORK_RESET;
        else if (copy_state_reg == gp_pin_pkg::COPY_LOAD) work_reg[n] <= nv_reg[n];
        else if (wr_work[n]) work_reg[n] <= wdata_reg & `GP_SET_MASK;
      end

      pin_cell u_cell (
        .setting_in(gp_pin_pkg::pin_setting_s'(work_reg[n])),
        .alt_valid_in(alt_valid[n]),
        .alt_drive_in(alt_drive[n]),
        .alt_level_in(alt_level[n]),
        .drive_out(drive_next[n]),
        .level_out(level_next[n])
      );
      assign alt_valid[n] = alt_ok(2'(n), fsel[n]);
    end
  endgenerate

  // alternate function routing; analog codes leave the digital driver off
  assign alt_drive[0] = 1'b1;
  assign alt_level[0] = (fsel[0] == `GP_FN_DEDICATED) ? alt_sources_in.suspend_indicator
                      : alt_sources_in.uart_receive_activity_lamp;
  assign alt_drive[1] = (fsel[1] == `GP_FN_DEDICATED) | (fsel[1] == `GP_FN_ALT1);
  assign alt_level[1] = (fsel[1] == `GP_FN_DEDICATED) ? alt_sources_in.clock_out
                      : alt_sources_in.uart_transmit_activity_lamp;
  assign alt_drive[2] = fsel[2] == `GP_FN_DEDICATED;
  assign alt_level[2] = alt_sources_in.bus_configured_indicator;
  assign alt_drive[3] = fsel[3] == `GP_FN_DEDICATED;
  assign alt_level[3] = alt_sources_in.two_wire_traffic_lamp;

  always_ff @(posedge clock_in) begin
    if (reset_in) ctrl_reg <= `GP_CTRL_RESET;
    else if (wr_ctrl) ctrl_reg <= wdata_reg & `GP_CTRL_MASK;
  end

  pin_sync u_sync (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .async_in(pin_in),
    .sync_out(pin_level)
  );

  // the synchroniser leaves reset low while an idle pin may sit high, so the
  // detector stays off until both stages and the previous sample hold real levels
  assign edge_armed = settle_reg == `GP_SETTLE_DONE;

  always_ff @(posedge clock_in) begin
    if (reset_in) settle_reg <= 2'h0;
    else if (!edge_armed) settle_reg <= settle_reg + 2'h1;
  end

  // edge detector on pin 1; the previous sample runs always so that
  // selecting the detector on a steady pin raises no false edge
  assign rise = pin_level[1] & ~pin1_prev_reg;
  assign fall = ~pin_level[1] & pin1_prev_reg;
  assign trig = edge_armed & (fsel[1] == `GP_FN_ALT2) &
                ((fall & ctrl_reg[`GP_CTRL_FALL]) | (rise & ctrl_reg[`GP_CTRL_RISE]));
  assign flag_clr = wr_stat & wdata_reg[`GP_STAT_FLAG];
  // a new edge beats a clear in the same cycle
  assign detector_flag_next = trig | (detector_flag_reg & ~flag_clr);

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pin1_prev_reg <= 1'b0;
      detector_flag_reg <= 1'b0;
      pin_out_reg <= 4'h0;
      pin_oe_reg <= 4'h0;
      ain_reg <= 3'h0;
      aout_reg <= 2'h0;
    end else begin
      pin1_prev_reg <= pin_level[1];
      detector_flag_reg <= detector_flag_next;
      pin_out_reg <= level_next;
      pin_oe_reg <= drive_next;
      ain_reg <= {fsel[3] == `GP_FN_ALT0, fsel[2] == `GP_FN_ALT0, fsel[1] == `GP_FN_ALT0};
      aout_reg <= {fsel[3] == `GP_FN_ALT1, fsel[2] == `GP_FN_ALT1};
    end
  end

  assign s_axi_awready_out = awready_reg;
  assign s_axi_wready_out = wready_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_arready_out = arready_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe_out = pin_oe_reg;
  assign analog_in_connect_out = ain_reg;
  assign analog_out_connect_out = aout_reg;
  assign detector_flag_out = detector_flag_reg;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  work_write_takes_a: assert property (wr_work[2]
    |=> work_reg[2] == ($past(wdata_reg) & 8'h1F))
    else $error("working byte did not take the write");
  boot_copy_loads_a: assert property (copy_state_reg == gp_pin_pkg::COPY_LOAD
    |=> work_reg[1] == $past(nv_reg[1]) && copy_state_reg == gp_pin_pkg::COPY_RUN)
    else $error("store image not copied to working copy");
  factory_image_a: assert property ($past(reset_in)
    |-> nv_reg[0] == 8'h12 && nv_reg[1] == 8'h13 && nv_reg[2] == 8'h11 && nv_reg[3] == 8'h11)
    else $error("factory image wrong after reset");
  gpio_out_drive_a: assert property (fsel[0] == 3'h0 && !work_reg[0][3]
    |=> pin_oe_out[0] && pin_out[0] == $past(work_reg[0][4]))
    else $error("plain output pin not driven at default level");
  gpio_in_float_a: assert property (fsel[3] == 3'h0 && work_reg[3][3] |=> !pin_oe_out[3])
    else $error("plain input pin is driven");
  reserved_floats_a: assert property (fsel[0] >= 3'h3 |=> !pin_oe_out[0] && !pin_out[0])
    else $error("reserved code drives pin 0");
  pin0_suspend_a: assert property (fsel[0] == 3'h1
    |=> pin_oe_out[0] && pin_out[0] == $past(alt_sources_in.suspend_indicator))
    else $error("pin 0 does not follow suspend indicator");
  pin1_clock_a: assert property (fsel[1] == 3'h1
    |=> pin_oe_out[1] && pin_out[1] == $past(alt_sources_in.clock_out))
    else $error("pin 1 does not carry clock");
  pin2_dac_a: assert property (fsel[2] == 3'h3
    |=> analog_out_connect_out[0] && !pin_oe_out[2])
    else $error("pin 2 analog output not connected");
  pin3_lamp_a: assert property (fsel[3] == 3'h1
    |=> pin_out[3] == $past(alt_sources_in.two_wire_traffic_lamp))
    else $error("pin 3 does not follow two-wire lamp");
  fall_edge_flag_a: assert property (fsel[1] == 3'h4 && ctrl_reg[6] && edge_armed
    && $fell(pin_level[1]) |=> detector_flag_out)
    else $error("falling edge missed by detector");
  no_enable_no_flag_a: assert property (!detector_flag_out && (fsel[1] != 3'h4
    || ctrl_reg[6:5] == 2'b00) |=> !detector_flag_out)
    else $error("detector flag set without enabled edge");
  read_answer_a: assert property (ar_taken && s_axi_araddr_in == 8'h04
    |=> s_axi_rvalid_out && s_axi_rdata_out[7:0] == $past(work_reg[1]))
    else $error("setting byte 1 not returned at its index");
  unarmed_quiet_a: assert property (!edge_armed |=> !detector_flag_out)
    else $error("detector flag raised before pin samples settled");
  pin1_reserved_a: assert property (fsel[1] > 3'h4
    |=> !pin_oe_out[1] && !pin_out[1] && !analog_in_connect_out[0])
    else $error("reserved code drives or connects pin 1");

  work_write_c: cover property (wr_work[0] ##1 pin_oe_out[0]);
  detector_hit_c: cover property (trig ##1 detector_flag_out);
  reload_c: cover property (reload_req ##1 copy_state_reg == gp_pin_pkg::COPY_LOAD);
  set_over_clear_c: cover property (trig && flag_clr);
endmodule : gp_pin_function_settings

// ===== dv/pin_partner.sv
// far-side circuitry on the four general purpose pins
`timescale 1ns/10ps
module pin_partner (
  input wire logic [3:0] pin_out_in,
  input wire logic [3:0] pin_oe_in,
  input wire logic [3:0] ext_oe_in,
  input wire logic [3:0] ext_level_in,
  output logic [3:0] pin_level_out
);
  // an undriven pin sits at its pull-up level, never at a stale value
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pin_oe_in[i]) begin
        pin_level_out[i] = pin_out_in[i];
      end else if (ext_oe_in[i]) begin
        pin_level_out[i] = ext_level_in[i];
      end else begin
        pin_level_out[i] = 1'b1;
      end
    end
  end
endmodule : pin_partner

// ===== dv/tb_top.sv
// self-checking bench for the pin function settings block
`timescale 1ns/10ps
module tb_top;
  logic clock_in, reset_in, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, flag;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, aout;
  logic [2:0] ain;
  logic [3:0] pin_lvl, pin_q, oe_q, ext_oe, ext_lvl, wstrb;
  gp_pin_pkg::alt_sources_s alt;
  logic [7:0] work [4];
  int n_mismatch, checked;

  gp_pin_function_settings uut (.clock_in(clock_in), .reset_in(reset_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .alt_sources_in(alt),
    .pin_in(pin_lvl), .pin_out(pin_q), .pin_oe_out(oe_q), .analog_in_connect_out(ain),
    .analog_out_connect_out(aout), .detector_flag_out(flag));

  pin_partner u_far (.pin_out_in(pin_q), .pin_oe_in(oe_q), .ext_oe_in(ext_oe),
    .ext_level_in(ext_lvl), .pin_level_out(pin_lvl));

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // handshakes are judged mid-cycle, where values equal those at the next rising edge
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
    logic aw_hs, w_hs;
    @(posedge clock_in);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clock_in);
      aw_hs = awvalid & awready;
      w_hs = wvalid & wready;
      @(posedge clock_in);
      awvalid <= awvalid & ~aw_hs;
      wvalid <= wvalid & ~w_hs;
    end while ((awvalid & ~aw_hs) | (wvalid & ~w_hs));
    do @(negedge clock_in); while (bvalid !== 1'b1);
    resp = bresp;
    @(posedge clock_in);
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ar_hs;
    @(posedge clock_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clock_in);
      ar_hs = arvalid & arready;
      @(posedge clock_in);
      arvalid <= arvalid & ~ar_hs;
    end while (!ar_hs);
    do @(negedge clock_in); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    @(posedge clock_in);
    rready <= 1'b0;
  endtask : axi_read

  task automatic reg_wr(input int idx, input logic [7:0] d);
    logic [1:0] r;
    axi_write(8'(idx * 4), d, r);
    chk("write response", 32'h0, {30'h0, r});
  endtask : reg_wr

  task automatic reg_chk(input string what, input int idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(8'(idx * 4), d, r);
    chk(what, {24'h0, exp}, d);
  endtask : reg_chk

  function automatic logic [1:0] exp_drive(input int p, input logic [7:0] b, input logic [5:0] al);
    int s;
    s = -1;
    if (b[2:0] == 3'h0) return b[3] ? 2'b00 : {1'b1, b[4]};
    if (b[2:0] == 3'h1) s = (p == 0) ? 5 : (p == 1) ? 0 : (p == 2) ? 2 : 1;
    if (b[2:0] == 3'h2 && p == 0) s = 4;
    if (b[2:0] == 3'h3 && p == 1) s = 3;
    return (s < 0) ? 2'b00 : {1'b1, al[s]};
  endfunction : exp_drive

  // two opposite source patterns so a lamp routed to a source an odd number of fields away shows up
  task automatic check_pins();
    logic [12:0] e;
    logic [1:0] d;
    for (int k = 0; k < 2; k++) begin
      @(posedge clock_in);
      alt <= k ? 6'h15 : 6'h2A;
      repeat (2) @(posedge clock_in);
      @(negedge clock_in);
      e = 13'h0;
      for (int p = 0; p < 4; p++) begin
        d = exp_drive(p, work[p], alt);
        e[9 + p] = d[1];
        e[5 + p] = d[0];
        if (p > 0 && work[p][2:0] == 3'h2) e[p + 1] = 1'b1;
        if (p > 1 && work[p][2:0] == 3'h3) e[p - 2] = 1'b1;
      end
      chk("pins", {19'h0, e}, {19'h0, oe_q, pin_q, ain, aout});
    end
  endtask : check_pins

  task automatic t_power_up();
    work = '{8'h12, 8'h13, 8'h11, 8'h11};
    for (int i = 0; i < 4; i++) begin
      reg_chk("working byte", i, work[i]);
      reg_chk("stored byte", i + 4, work[i]);
    end
    reg_chk("control", 8, 8'h60);
    check_pins();
  endtask : t_power_up

  task automatic t_codes();
    for (int p = 0; p < 4; p++) begin
      for (int v = 0; v < 32; v++) begin
        work[p] = 8'(v);
        reg_wr(p, work[p]);
        reg_chk("working byte", p, work[p]);
        check_pins();
      end
    end
  endtask : t_codes

  task automatic t_image();
    logic [7:0] img [4];
    img = '{8'h10, 8'h00, 8'h18, 8'h03};
    for (int p = 0; p < 4; p++) begin
      reg_wr(p + 4, img[p]);
      reg_chk("working kept", p, work[p]);
    end
    check_pins();
    reg_wr(8, 8'h61);
    work = img;
    reg_chk("control", 8, 8'h60);
    for (int p = 0; p < 4; p++) reg_chk("reloaded byte", p, work[p]);
    check_pins();
  endtask : t_image

  // each step: enables, clear flag, move pin one, expected flag
  task automatic t_detect();
    logic [9:0] st [8];
    st = '{{8'h60, 2'b11}, {8'h60, 2'b01}, {8'h40, 2'b10}, {8'h40, 2'b01},
           {8'h20, 2'b11}, {8'h20, 2'b00}, {8'h00, 2'b10}, {8'h00, 2'b00}};
    work[1] = 8'h04;
    reg_wr(1, work[1]);
    @(posedge clock_in);
    ext_oe <= 4'h2;
    ext_lvl <= 4'h0;
    for (int i = 0; i < 8; i++) begin
      reg_wr(8, st[i][9:2]);
      reg_wr(9, 8'h01);
      @(posedge clock_in);
      ext_lvl <= {2'b00, st[i][1], 1'b0};
      repeat (6) @(posedge clock_in);
      @(negedge clock_in);
      chk("detector flag", {31'h0, st[i][0]}, {31'h0, flag});
      // pin 0 drives high, pins 2 and 3 float to the pull-up, pin 1 follows the far side
      reg_chk("status", 9, {2'b11, st[i][1], 1'b1, 3'h0, st[i][0]});
    end
    @(posedge clock_in);
    ext_oe <= 4'h0;
  endtask : t_detect

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    axi_read(8'h28, d, r);
    chk("unmapped read response", 32'h2, {30'h0, r});
    chk("unmapped read data", 32'h0, d);
    axi_write(8'h40, 8'h00, r);
    chk("unmapped write response", 32'h2, {30'h0, r});
    reg_chk("working kept", 0, work[0]);
    @(posedge clock_in);
    wstrb <= 4'h0;
    axi_write(8'h00, 8'h1F, r);
    chk("unstrobed write response", 32'h0, {30'h0, r});
    reg_chk("unstrobed byte kept", 0, work[0]);
    wstrb <= 4'h1;
  endtask : t_unmapped

  task automatic finish_test();
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    alt = 6'h00;
    {ext_oe, ext_lvl} = 8'h00;
    wstrb = 4'h1;
    reset_in = 1'b1;
    repeat (12) @(posedge clock_in);
    reset_in <= 1'b0;
    t_power_up();
    t_codes();
    t_image();
    t_detect();
    t_unmapped();
    finish_test();
  end

  // the full run takes well under 10000 cycles
  initial begin
    #500000;
    n_mismatch++;
    finish_test();
  end
endmodule : tb_top
